// ===== verilog/hfb_regs.sv
// top: fan pin control, bank select, vendor id and beep enable registers
`timescale 1ns/1ps
`include "hfb_params.svh"
module hfb_regs
    import hfb_pkg::*;
(
    // clock and reset
    input  wire logic      ref_clk,
    input  wire logic      nrst,
    // register port
    input  wire hfb_byte_t regAddr,
    input  wire hfb_byte_t regWdata,
    input  wire logic      regWr,
    input  wire logic      regRd,
    output hfb_byte_t      regRdata,
    // fan pins
    input  wire logic      cpuFanPinIn,
    input  wire logic      sysFanPinIn,
    output logic           cpuFanPinOut,
    output logic           cpuFanPinOe_n,
    output logic           sysFanPinOut,
    output logic           sysFanPinOe_n,
    output logic           cpuTachSync,
    output logic           sysTachSync,
    // limit violations, bit7 cpu fan down to bit0 core voltage, same clock
    input  wire hfb_byte_t limitViolation,
    // window state and beep
    output logic [2:0]     windowBank,
    output logic           beepOut
);
    // id held as a 16-bit constant so each half is taken by part-select, not by shifting
    localparam logic [15:0] VendorId = `HFB_VENDOR_ID;
    hfb_byte_t fan_q, fan_d, sel_q, sel_d, beep1_q, beep1_d, rd_q, rd_d;
    logic      gate_q, gate_d;
    logic [2:0] bank_q;
    hfb_pin_if pinBus();

    // ==========================================
    // register writes; bank-select reserved bits are stored as written
    always_comb begin
        fan_d   = fan_q;
        sel_d   = sel_q;
        beep1_d = beep1_q;
        gate_d  = gate_q;
        if (regWr) begin
            if (regAddr == `HFB_IDX_FANCTL)  fan_d = {4'h0, regWdata[3:0]};
            if (regAddr == `HFB_IDX_BANKSEL) sel_d = regWdata;
            if (sel_q[2:0] == `HFB_BANK_ZERO) begin
                if (regAddr == `HFB_IDX_BEEP1) beep1_d = regWdata;
                if (regAddr == `HFB_IDX_BEEP2) gate_d = regWdata[`HFB_GATE_BIT];
            end
        end
    end
    // ==========================================
    // read mux: one cycle latency, unmapped and reserved read zero
    always_comb begin
        rd_d = 8'h00;
        if (regRd) begin
            if (regAddr == `HFB_IDX_FANCTL) rd_d = fan_q;
            else if (regAddr == `HFB_IDX_BANKSEL) rd_d = sel_q;
            else if (regAddr == `HFB_IDX_VENDOR)
                rd_d = sel_q[`HFB_SEL_UPPER] ? VendorId[15:8] : VendorId[7:0];
            else if (sel_q[2:0] == `HFB_BANK_ZERO) begin
                if (regAddr >= `HFB_IDX_RSV_LO && regAddr <= `HFB_IDX_RSV_HI) rd_d = 8'h00;
                else if (regAddr == `HFB_IDX_BEEP1) rd_d = beep1_q;
                else if (regAddr == `HFB_IDX_BEEP2) rd_d = {gate_q, 7'h00};
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            fan_q   <= `HFB_RST_FANCTL & 8'h0f;
            sel_q   <= `HFB_RST_BANKSEL;
            beep1_q <= `HFB_RST_BEEP1;
            gate_q  <= `HFB_RST_GATE;
            rd_q    <= 8'h00;
            bank_q  <= 3'h0;
        end else begin
            fan_q   <= fan_d;
            sel_q   <= sel_d;
            beep1_q <= beep1_d;
            gate_q  <= gate_d;
            rd_q    <= rd_d;
            bank_q  <= sel_d[2:0];
        end
    end
    // pin control fields
    assign pinBus.cpuTach = fan_q[`HFB_FAN_CPU_TACH];
    assign pinBus.cpuLvl  = fan_q[`HFB_FAN_CPU_LVL];
    assign pinBus.sysTach = fan_q[`HFB_FAN_SYS_TACH];
    assign pinBus.sysLvl  = fan_q[`HFB_FAN_SYS_LVL];
    assign regRdata   = rd_q;
    assign windowBank = bank_q;

    hfb_fan_pins uPins (
        .ref_clk    (ref_clk),
        .nrst       (nrst),
        .ctl        (pinBus),
        .cpuPinIn   (cpuFanPinIn),
        .sysPinIn   (sysFanPinIn),
        .cpuPinOut  (cpuFanPinOut),
        .cpuPinOe_n (cpuFanPinOe_n),
        .sysPinOut  (sysFanPinOut),
        .sysPinOe_n (sysFanPinOe_n),
        .cpuTachSync(cpuTachSync),
        .sysTachSync(sysTachSync)
    );
    hfb_beep uBeep (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .enables  (beep1_q),
        .gate     (gate_q),
        .violation(limitViolation),
        .beep     (beepOut)
    );
endmodule // hfb_regs

// ===== verilog/hfb_params.svh
// constant definitions for the fan pin, bank select and beep register slice
// ==========================================
// Functional notes
// - fan control bit2 set makes cpu pin tach
// - bit2 clear makes cpu pin an output
// - cpu pin output level follows bit3, reset zero
// - fan control bit0 set makes system pin tach
// - bit0 clear makes system pin an output
// - system pin output level follows bit1, reset zero
// - select bit7 picks id high or low byte
// - select bits 2..0 pick window bank
// - sixteen bit read-only id at one index
// - bank zero indices 50h-55h are reserved
// - beep enable one holds eight channel enables
// - global beep gate blocks every beep source
`ifndef HFB_PARAMS_SVH
`define HFB_PARAMS_SVH
// ==========================================
// register indices
`define HFB_IDX_FANCTL    8'h4d
`define HFB_IDX_BANKSEL   8'h4e
`define HFB_IDX_VENDOR    8'h4f
`define HFB_IDX_RSV_LO    8'h50
`define HFB_IDX_RSV_HI    8'h55
`define HFB_IDX_BEEP1     8'h56
`define HFB_IDX_BEEP2     8'h57
// ==========================================
// reset values
`define HFB_RST_FANCTL    8'h95
`define HFB_RST_BANKSEL   8'hc8
`define HFB_RST_BEEP1     8'h00
`define HFB_RST_GATE      1'b1
// vendor id value is arbitrary
`define HFB_VENDOR_ID     16'h1234
// ==========================================
// field positions
`define HFB_FAN_CPU_LVL   3
`define HFB_FAN_CPU_TACH  2
`define HFB_FAN_SYS_LVL   1
`define HFB_FAN_SYS_TACH  0
`define HFB_SEL_UPPER     7
`define HFB_SEL_RSV6      6
`define HFB_SEL_RSV3      3
`define HFB_GATE_BIT      7
`define HFB_BANK_ZERO     3'h0
`endif

// ===== verilog/hfb_pkg.sv
// types shared by the fan pin, bank select and beep register slice
package hfb_pkg;
    typedef logic [7:0] hfb_byte_t;
    typedef enum logic [1:0] {HFB_IDLE, HFB_READ} hfb_acc_e;
endpackage

// ===== verilog/hfb_pin_if.sv
// interface carrying fan pin control between the register bank and pin driver
`timescale 1ns/1ps
interface hfb_pin_if;
    logic cpuTach;
    logic cpuLvl;
    logic sysTach;
    logic sysLvl;
    modport regs (output cpuTach, cpuLvl, sysTach, sysLvl);
    modport pins (input cpuTach, cpuLvl, sysTach, sysLvl);
endinterface

// ===== verilog/hfb_fan_pins.sv
// fan pin driver: tach input synchroniser and output drive
`timescale 1ns/1ps
`include "hfb_params.svh"
module hfb_fan_pins
    import hfb_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic nrst,
    // control from the register bank
    hfb_pin_if.pins   ctl,
    // pins
    input  wire logic cpuPinIn,
    input  wire logic sysPinIn,
    output logic      cpuPinOut,
    output logic      cpuPinOe_n,
    output logic      sysPinOut,
    output logic      sysPinOe_n,
    output logic      cpuTachSync,
    output logic      sysTachSync
);
    logic [1:0] s1_q, s1_d, s2_q, s2_d;
    logic [3:0] drv_q, drv_d;
    // next values: sync stages and pin drive, enable low while driving
    always_comb begin
        s1_d = {cpuPinIn, sysPinIn};
        s2_d = s1_q;
        drv_d[0] = ctl.cpuLvl;
        drv_d[1] = ctl.cpuTach;
        drv_d[2] = ctl.sysLvl;
        drv_d[3] = ctl.sysTach;
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s1_q  <= 2'h0;
            s2_q  <= 2'h0;
            drv_q <= 4'ha;                        // both pins released as tach
        end else begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            drv_q <= drv_d;
        end
    end
    // tach samples only mean something while the pin is an input
    assign cpuTachSync = s2_q[1];
    assign sysTachSync = s2_q[0];
    assign cpuPinOut   = drv_q[0];
    assign cpuPinOe_n  = drv_q[1];
    assign sysPinOut   = drv_q[2];
    assign sysPinOe_n  = drv_q[3];
endmodule // hfb_fan_pins

// ===== verilog/hfb_beep.sv
// beep combiner: enabled violations gated by the global gate
`timescale 1ns/1ps
`include "hfb_params.svh"
module hfb_beep
    import hfb_pkg::*;
(
    // clock and reset
    input  wire logic      ref_clk,
    input  wire logic      nrst,
    // enables and violations
    input  wire hfb_byte_t enables,
    input  wire logic      gate,
    input  wire hfb_byte_t violation,
    // output
    output logic           beep
);
    logic [7:0] hit;
    logic       beep_q, beep_d;
    // one and-term per channel
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : gCh
            assign hit[g] = enables[g] & violation[g];
        end
    endgenerate
    always_comb begin
        beep_d = gate & (|hit);
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) beep_q <= 1'b0;
        else       beep_q <= beep_d;
    end
    assign beep = beep_q;
endmodule // hfb_beep

// ===== tb/hfb_regs_asserts.sv
// checker: port-level relations of the fan pin, bank select and beep register slice
`timescale 1ns/1ps
`include "hfb_params.svh"
module hfb_regs_asserts
    import hfb_pkg::*;
(
    // clock and reset
    input wire logic      ref_clk,
    input wire logic      nrst,
    // watched ports
    input wire hfb_byte_t regAddr,
    input wire hfb_byte_t regWdata,
    input wire logic      regWr,
    input wire logic      regRd,
    input wire hfb_byte_t regRdata,
    input wire logic      cpuFanPinOut,
    input wire logic      cpuFanPinOe_n,
    input wire logic      sysFanPinOut,
    input wire logic      sysFanPinOe_n,
    input wire hfb_byte_t limitViolation,
    input wire logic [2:0] windowBank,
    input wire logic      beepOut
);
    // ==========================================
    // properties: pins follow a fan write two cycles later
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    wire fanWr = regWr && regAddr == `HFB_IDX_FANCTL;
    property p_cpu_oe; hfb_byte_t d; (fanWr, d = regWdata) |-> ##2 cpuFanPinOe_n == d[2]; endproperty
    a_cpu_oe: assert property (p_cpu_oe) else $error("cpu pin mode wrong");
    property p_cpu_lvl; hfb_byte_t d; (fanWr && !regWdata[2], d = regWdata) |-> ##2 cpuFanPinOut == d[3]; endproperty
    a_cpu_lvl: assert property (p_cpu_lvl) else $error("cpu pin level wrong");
    property p_sys_oe; hfb_byte_t d; (fanWr, d = regWdata) |-> ##2 sysFanPinOe_n == d[0]; endproperty
    a_sys_oe: assert property (p_sys_oe) else $error("sys pin mode wrong");
    property p_sys_lvl; hfb_byte_t d; (fanWr && !regWdata[0], d = regWdata) |-> ##2 sysFanPinOut == d[1]; endproperty
    a_sys_lvl: assert property (p_sys_lvl) else $error("sys pin level wrong");
    property p_bank; hfb_byte_t d; (regWr && regAddr == `HFB_IDX_BANKSEL, d = regWdata) |=> windowBank == d[2:0]; endproperty
    a_bank: assert property (p_bank) else $error("window bank wrong");
    property p_rsv; regRd && regAddr inside {[`HFB_IDX_RSV_LO:`HFB_IDX_RSV_HI]} |=> regRdata == 8'h00; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved index read nonzero");
    property p_rd_idle; !regRd |=> regRdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside answer cycle");
    // a beep can only follow a violation seen on the previous edge
    property p_beep; beepOut |-> $past(limitViolation) != 8'h00; endproperty
    a_beep: assert property (p_beep) else $error("beep without violation");
endmodule // hfb_regs_asserts
bind hfb_regs hfb_regs_asserts u_hfb_regs_asserts (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cpuFanPinOut(cpuFanPinOut),
    .cpuFanPinOe_n(cpuFanPinOe_n), .sysFanPinOut(sysFanPinOut), .sysFanPinOe_n(sysFanPinOe_n),
    .limitViolation(limitViolation), .windowBank(windowBank), .beepOut(beepOut));

// ===== tb/test_hfb_regs.sv
// self-checking bench for the fan pin, bank select and beep register slice
`timescale 1ns/1ps
`include "hfb_params.svh"
module test_hfb_regs;
    import hfb_pkg::*;
    localparam logic [15:0] VID = `HFB_VENDOR_ID;
    logic        ref_clk = 1'b0;
    logic        nrst    = 1'b0;
    logic        regWr   = 1'b0;
    logic        regRd   = 1'b0;
    logic        cpuIn   = 1'b0;
    logic        sysIn   = 1'b0;
    hfb_byte_t   regAddr = 8'h00;
    hfb_byte_t   regWdata = 8'h00;
    hfb_byte_t   limitViolation = 8'h00;
    hfb_byte_t   regRdata, r, e, v;
    logic        cpuOut, cpuOe_n, sysOut, sysOe_n, beepOut, g;
    logic [2:0]  windowBank;
    logic        cpuSync, sysSync;
    logic [1:0]  tachH1 = 2'h0, tachH2 = 2'h0;
    logic [31:0] lfsr = 32'h5e271934;
    int          num_errors = 0;
    int          checked = 0;
    int          cyc = 0;
    hfb_regs u_hfb_regs (.ref_clk(ref_clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdata), .cpuFanPinIn(cpuIn), .sysFanPinIn(sysIn), .cpuFanPinOut(cpuOut),
        .cpuFanPinOe_n(cpuOe_n), .sysFanPinOut(sysOut), .sysFanPinOe_n(sysOe_n), .cpuTachSync(cpuSync),
        .sysTachSync(sysSync), .limitViolation(limitViolation), .windowBank(windowBank), .beepOut(beepOut));
    // ==========================================
    // helpers: random source, expected beep, bus cycles, compare, verdict
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic beepExp(input hfb_byte_t en, input hfb_byte_t vi, input logic gt);
        return gt & (|(en & vi));
    endfunction
    task automatic chk(input string n, input hfb_byte_t s, input hfb_byte_t x);
        checked++;
        if (s !== x) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask
    task automatic wr(input hfb_byte_t a, input hfb_byte_t d);
        @(posedge ref_clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge ref_clk);
        regWr    <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input hfb_byte_t a, output hfb_byte_t d);
        @(posedge ref_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge ref_clk);
        regRd   <= 1'b0;
        #1;
        d = regRdata;
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ==========================================
    // clock, random pin activity and hang guard
    initial forever #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        lfsr = nxt(lfsr);
        {cpuIn, sysIn} <= lfsr[1:0];
        tachH1 <= {cpuIn, sysIn};                 // pin levels reach the tach outputs after two flops
        tachH2 <= tachH1;
        cyc++;
        if (cyc == 5000) begin
            num_errors++;
            wrap_up();
        end
    end
    // ==========================================
    // main sequence
    initial begin
        repeat (16) @(posedge ref_clk);
        nrst <= 1'b1;
        rd(`HFB_IDX_FANCTL, r);
        chk("fan reset", r & 8'h0f, 8'h05);
        chk("pins released", {cpuOe_n, sysOe_n}, 8'h03);
        rd(`HFB_IDX_BANKSEL, r);
        chk("select reset", r & 8'h87, 8'h80);
        rd(`HFB_IDX_VENDOR, r);
        chk("id upper", r, VID[15:8]);
        wr(`HFB_IDX_BANKSEL, 8'h48); // bits 6 and 3 kept set
        wr(`HFB_IDX_VENDOR, 8'h5a);
        rd(`HFB_IDX_VENDOR, r);
        chk("id lower", r, VID[7:0]);
        wr(`HFB_IDX_BANKSEL, 8'hc8);
        rd(`HFB_IDX_BEEP1, r);
        chk("beep1 reset", r, 8'h00);
        // every mode and level pair of both fan pins
        for (int i = 0; i < 16; i++) begin
            wr(`HFB_IDX_FANCTL, i[7:0]);
            repeat (2) @(posedge ref_clk);
            #1;
            chk("cpu mode", cpuOe_n, i[2]);
            chk("cpu level", cpuOut | i[2], i[3] | i[2]);
            chk("sys mode", sysOe_n, i[0]);
            chk("sys level", sysOut | i[0], i[1] | i[0]);
            chk("tach sync", {cpuSync, sysSync}, tachH2);
        end
        for (int a = 8'h50; a <= 8'h55; a++) begin
            wr(a[7:0], lfsr[7:0]);
            rd(a[7:0], r);
            chk("reserved", r, 8'h00);
        end
        // beep enables are out of reach from any other bank
        for (int b = 1; b < 8; b++) begin
            wr(`HFB_IDX_BANKSEL, 8'hc8 | b[7:0]);
            wr(`HFB_IDX_BEEP1, 8'hff);
            rd(`HFB_IDX_BEEP1, r);
            chk("bank", {5'h00, windowBank}, b[7:0]);
            chk("other bank", r, 8'h00);
        end
        wr(`HFB_IDX_BANKSEL, 8'hc8);
        rd(`HFB_IDX_BEEP1, r);
        chk("bank zero", r, 8'h00);
        // single channels first, then random mixes with the gate sometimes closed
        for (int k = 0; k < 24; k++) begin
            e = (k < 8) ? (8'h01 << k) : lfsr[15:8];
            v = (k < 8) ? (8'h01 << k) : lfsr[23:16];
            g = (k < 8) || (k[1:0] != 2'b11);
            wr(`HFB_IDX_BEEP1, e);
            wr(`HFB_IDX_BEEP2, {g, 7'h00});
            rd(`HFB_IDX_BEEP1, r);
            chk("beep enables", r, e);
            @(posedge ref_clk);
            limitViolation <= v;
            repeat (2) @(posedge ref_clk);
            #1;
            chk("beep", beepOut, beepExp(e, v, g));
        end
        wrap_up();
    end
endmodule // test_hfb_regs
